/* File: core/fbs_sequencer.sv */
`timescale 1ns/1ps
// Summary of operation
// - Bias above turn-on threshold enables switching and turns the startup switch off.
// - Bias below turn-off threshold stops operation and turns the startup switch on.
// - First four cycles after enable (one line-wait cycle, then three probe cycles) use the minimum peak current limit.
// - After those cycles, aux sample below entry level enters special startup mode.
// - Special startup caps peak near 0.63 of maximum and raises duty reference.
// - Aux sample above exit level leaves special startup, restoring normal limits.
// - Constant-current regulation runs until output regulation, then normal control law.
// - Overvoltage sample stops switching and draws fault current until bias turn-off.
// - After fault discharge to turn-off, the device restarts the full startup sequence.
// - Every fault uses the same lockout reset and restart, never a latch.
// - Each cycle ends when sensed current reaches that cycle's selected threshold.
// - Peak comparator is ignored during leading-edge blanking after each turn-on.
// - Overcurrent level triggers reset and restart, never masked by blanking.
// - Line run and stop currents are judged only during gate on-time.
// - Overtemperature starts a reset cycle; if still hot at its end, the device stays off with the startup switch on until cool.
// - Complete loss of aux feedback stops switching and then restarts.
// - Gate turn-on waits for a valley unless ringing is too small to detect; in line wait it turns on once period_min is reached.
// - Periods are quantized to valley-aligned lengths by skipping valleys as needed.
module fbs_sequencer
    import fbs_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic             ref_clk,           // Device clock, 125 MHz.
    input  wire logic             reset,             // Synchronous reset, active high.
    input  wire logic             bias_above_on,     // Comparator: bias at or above turn-on threshold.
    input  wire logic             bias_below_off,    // Comparator: bias below turn-off threshold.
    input  wire logic             cs_trip,           // Comparator: current sense at selected threshold.
    input  wire logic             cs_ocp,            // Comparator: current sense at overcurrent level.
    input  wire logic             aux_sample_valid,  // Level: aux sample at end of demagnetization held.
    input  wire logic             aux_below_enter,   // Comparator: aux sample below startup entry level.
    input  wire logic             aux_above_exit,    // Comparator: aux sample above startup exit level.
    input  wire logic             aux_ovp,           // Comparator: aux sample above overvoltage level.
    input  wire logic             aux_lost,          // Detector: aux feedback completely lost.
    input  wire logic             demag_done,        // Level: secondary demagnetization finished.
    input  wire logic             valley_det,        // Comparator: drain voltage valley.
    input  wire logic             ring_timeout,      // Detector: ringing decayed, no valley found.
    input  wire logic             line_run,          // Comparator: aux current above run level.
    input  wire logic             line_stop,         // Comparator: aux current below stop level.
    input  wire logic             over_temp,         // Comparator: junction over temperature.
    input  wire logic             in_regulation,     // Comparator: output in voltage regulation.
    input  wire logic [CNT_W-1:0] period_min,        // Least period in clocks from the control law.
    input  wire logic [LIMIT_W-1:0] law_limit,       // Peak limit code from the control law.
    output logic                  gate_drive_out,    // Gate command, high turns the switch on.
    output logic                  startup_switch_on, // High-voltage startup switch enable.
    output logic                  fault_current_on,  // Draws fault current to discharge bias.
    output logic [LIMIT_W-1:0]    peak_limit,        // Selected peak current threshold code.
    output logic [LIMIT_W-1:0]    demag_duty_reference, // Demagnetization duty reference code.
    output logic                  startup_mode,      // Special startup mode active.
    output logic                  cc_mode            // Constant-current regulation active.
);
    localparam int NIN = 16;
    localparam int BLANK_W = $clog2(BLANK_CYCLES + 1);

    initial begin
        if (CNT_W < 8) $error("fbs_sequencer CNT_W too small");
    end

    fbs_sync_if #(.WIDTH(NIN)) sync_bus ();

    assign sync_bus.raw = {bias_above_on, bias_below_off, cs_trip, cs_ocp, aux_sample_valid,
                           aux_below_enter, aux_above_exit, aux_ovp, aux_lost, demag_done,
                           valley_det, ring_timeout, line_run, line_stop, over_temp, in_regulation};

    fbs_sync #(.WIDTH(NIN)) u_sync (
        .ref_clk (ref_clk),
        .reset   (reset),
        .port    (sync_bus)
    );

    logic s_on, s_off, s_cs, s_ocp, s_smp, s_enter, s_exit, s_ovp;
    logic s_lost, s_demag, s_valley, s_rto, s_run, s_stop, s_hot, s_reg;
    assign {s_on, s_off, s_cs, s_ocp, s_smp, s_enter, s_exit, s_ovp,
            s_lost, s_demag, s_valley, s_rto, s_run, s_stop, s_hot, s_reg} = sync_bus.clean;

    fbs_state_t           state_q, state_d;
    fbs_phase_t           phase_q, phase_d;
    logic [1:0]           probe_q, probe_d;
    logic [BLANK_W-1:0]   blank_q, blank_d;
    logic [CNT_W-1:0]     per_q, per_d;
    logic                 ssm_q, ssm_d;
    logic                 cc_q, cc_d;
    logic                 gate_q, gate_d;
    logic                 hv_q, hv_d;
    logic                 flt_q, flt_d;
    logic                 smp_q, smp_d;
    logic                 fire;
    logic                 switching;

    assign switching = (state_q == FBS_PROBE) || (state_q == FBS_RUN);

    fbs_valley #(.CNT_W(CNT_W)) u_valley (
        .ref_clk      (ref_clk),
        .reset        (reset),
        .arm          (switching && (phase_q == FBS_PH_WAIT)),
        .period_min   (period_min),
        .period_cnt   (per_q),
        .valley       (s_valley),
        .ring_timeout (s_rto),
        .fire         (fire)
    );

    function automatic logic [LIMIT_W-1:0] pick_limit(input fbs_state_t st, input logic ssm,
                                                      input logic [LIMIT_W-1:0] law);
        logic [LIMIT_W-1:0] cap;
        cap = ssm ? LIMIT_SSM : LIMIT_MAX;
        if (st != FBS_RUN) begin
            pick_limit = LIMIT_MIN;
        end else if (law > cap) begin
            pick_limit = cap;
        end else if (law < LIMIT_MIN) begin
            pick_limit = LIMIT_MIN;
        end else begin
            pick_limit = law;
        end
    endfunction : pick_limit

    // Any fault leads to the same discharge and restart path.
    logic fault_now;
    always_comb begin
        fault_now = 1'b0;
        if (switching_or_line(state_q)) begin
            if (s_ocp) fault_now = 1'b1;
            if (s_hot) fault_now = 1'b1;
            if (s_lost) fault_now = 1'b1;
            if (s_smp && !smp_q && s_ovp) fault_now = 1'b1;
        end
    end

    always_comb begin
        state_d = state_q;
        phase_d = phase_q;
        probe_d = probe_q;
        blank_d = blank_q;
        per_d   = (per_q == {CNT_W{1'b1}}) ? per_q : per_q + 1'b1;
        ssm_d   = ssm_q;
        cc_d    = cc_q;
        gate_d  = 1'b0;
        hv_d    = hv_q;
        flt_d   = 1'b0;
        smp_d   = s_smp;
        case (state_q)
            FBS_OFF: begin
                hv_d    = 1'b1;
                phase_d = FBS_PH_IDLE;
                ssm_d   = 1'b0;
                cc_d    = 1'b0;
                if (s_on && !s_off && !s_hot) begin
                    state_d = FBS_LINEWT;
                    hv_d    = 1'b0;
                    phase_d = FBS_PH_WAIT;
                    per_d   = {CNT_W{1'b1}};
                    probe_d = 2'd0;
                end
            end
            FBS_LINEWT, FBS_PROBE, FBS_RUN: begin
                hv_d = 1'b0;
                case (phase_q)
                    FBS_PH_ON: begin
                        gate_d = 1'b1;
                        if (blank_q != '0) begin
                            blank_d = blank_q - 1'b1;
                        end else if (s_cs) begin
                            gate_d  = 1'b0;
                            phase_d = FBS_PH_DEMAG;
                        end
                        if (s_run && state_q == FBS_LINEWT) begin
                            state_d = FBS_PROBE;
                        end else if (s_stop && state_q != FBS_LINEWT) begin
                            state_d = FBS_LINEWT;
                        end
                    end
                    FBS_PH_DEMAG: begin
                        if (s_demag) phase_d = FBS_PH_WAIT;
                    end
                    FBS_PH_WAIT: begin
                        if (fire || (state_q == FBS_LINEWT && per_q >= period_min)) begin
                            phase_d = FBS_PH_ON;
                            gate_d  = 1'b1;
                            blank_d = BLANK_W'(BLANK_CYCLES);
                            per_d   = '0;
                            if (state_q == FBS_PROBE) begin
                                if (probe_q == 2'(PROBE_CYCLES)) begin
                                    state_d = FBS_RUN;
                                    ssm_d   = s_enter;
                                    cc_d    = 1'b1;
                                    probe_d = 2'd0;
                                end else begin
                                    probe_d = probe_q + 2'd1;
                                end
                            end
                        end
                    end
                    default: phase_d = FBS_PH_WAIT;
                endcase
                if (state_q == FBS_RUN) begin
                    if (ssm_q && s_smp && s_exit) ssm_d = 1'b0;
                    if (s_reg) cc_d = 1'b0;
                    else if (!cc_q && !s_reg && ssm_q) cc_d = 1'b1;
                end
                if (fault_now) begin
                    state_d = FBS_FAULT;
                    gate_d  = 1'b0;
                    flt_d   = 1'b1;
                end
                if (s_off) begin
                    state_d = FBS_OFF;
                    gate_d  = 1'b0;
                    hv_d    = 1'b1;
                end
            end
            FBS_FAULT: begin
                flt_d   = 1'b1;
                hv_d    = 1'b0;
                phase_d = FBS_PH_IDLE;
                if (s_off) begin
                    state_d = FBS_OFF;
                    flt_d   = 1'b0;
                    hv_d    = 1'b1;
                end
            end
            default: begin
                state_d = FBS_OFF;
                hv_d    = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q <= FBS_OFF;
            phase_q <= FBS_PH_IDLE;
            probe_q <= 2'd0;
            blank_q <= '0;
            per_q   <= '0;
            ssm_q   <= 1'b0;
            cc_q    <= 1'b0;
            gate_q  <= 1'b0;
            hv_q    <= 1'b1;
            flt_q   <= 1'b0;
            smp_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            phase_q <= phase_d;
            probe_q <= probe_d;
            blank_q <= blank_d;
            per_q   <= per_d;
            ssm_q   <= ssm_d;
            cc_q    <= cc_d;
            gate_q  <= gate_d;
            hv_q    <= hv_d;
            flt_q   <= flt_d;
            smp_q   <= smp_d;
        end
    end

    // Limit and reference are registered every clock from the next state, mode and law limit.
    logic [LIMIT_W-1:0] lim_q, lim_d, dref_q, dref_d;
    always_comb begin
        lim_d  = pick_limit(state_d, ssm_d, law_limit);
        dref_d = ssm_d ? DEMAG_SSM : DEMAG_NORMAL;
    end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            lim_q  <= LIMIT_MIN;
            dref_q <= DEMAG_NORMAL;
        end else begin
            lim_q  <= lim_d;
            dref_q <= dref_d;
        end
    end

    assign gate_drive_out       = gate_q && switching_or_line(state_q);
    assign startup_switch_on    = hv_q;
    assign fault_current_on     = flt_q;
    assign peak_limit           = lim_q;
    assign demag_duty_reference = dref_q;
    assign startup_mode         = ssm_q;
    assign cc_mode              = cc_q;

    function automatic logic switching_or_line(input fbs_state_t st);
        switching_or_line = (st == FBS_PROBE) || (st == FBS_RUN) || (st == FBS_LINEWT);
    endfunction : switching_or_line

endmodule : fbs_sequencer

/* File: core/fbs_sync.sv */
`timescale 1ns/1ps
module fbs_sync
    import fbs_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic ref_clk,  // Device clock.
    input  wire logic reset,    // Synchronous reset, active high.
    fbs_sync_if.dst   port      // Raw comparator levels in, filtered levels out.
);
    logic [WIDTH-1:0] s1_q, s2_q, s3_q, clean_q;
    logic [WIDTH-1:0] s1_d, s2_d, s3_d, clean_d;

    initial begin
        if (WIDTH < 1) $error("fbs_sync WIDTH must be at least one");
    end

    // A change is taken only once the second and third stages agree.
    always_comb begin
        s1_d    = port.raw;
        s2_d    = s1_q;
        s3_d    = s2_q;
        clean_d = clean_q;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                clean_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s1_q    <= '0;
            s2_q    <= '0;
            s3_q    <= '0;
            clean_q <= '0;
        end else begin
            s1_q    <= s1_d;
            s2_q    <= s2_d;
            s3_q    <= s3_d;
            clean_q <= clean_d;
        end
    end

    assign port.clean = clean_q;
endmodule : fbs_sync

/* File: core/fbs_valley.sv */
`timescale 1ns/1ps
module fbs_valley
    import fbs_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic             ref_clk,      // Device clock.
    input  wire logic             reset,        // Synchronous reset, active high.
    input  wire logic             arm,          // Level: waiting for the next turn-on.
    input  wire logic [CNT_W-1:0] period_min,   // Least period in clocks wanted by the control law.
    input  wire logic [CNT_W-1:0] period_cnt,   // Clocks since the last turn-on.
    input  wire logic             valley,       // Synchronized valley detect level.
    input  wire logic             ring_timeout, // Synchronized no-valley timeout level.
    output logic                  fire          // One-cycle turn-on request.
);
    logic valley_q, valley_d;
    logic fire_q, fire_d;

    initial begin
        if (CNT_W < 4) $error("fbs_valley CNT_W too small");
    end

    // Valleys seen before the period target are skipped; the first one after it fires.
    always_comb begin
        valley_d = valley;
        fire_d   = 1'b0;
        if (arm && !fire_q && (period_cnt >= period_min)) begin
            if (valley && !valley_q) begin
                fire_d = 1'b1;
            end else if (ring_timeout) begin
                fire_d = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            valley_q <= 1'b0;
            fire_q   <= 1'b0;
        end else begin
            valley_q <= valley_d;
            fire_q   <= fire_d;
        end
    end

    assign fire = fire_q;
endmodule : fbs_valley

/* File: shared/fbs_pkg.sv */
package fbs_pkg;

    // Leading-edge blanking time and its count at the 125 MHz clock.
    localparam int  CLK_PERIOD_PS     = 8000;
    localparam int  BLANK_TIME_PS     = 235000;
    localparam int  BLANK_CYCLES      = (BLANK_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int  PROBE_CYCLES      = 3;
    localparam int  SYNC_STAGES       = 3;

    // Peak current limit codes, full scale 1000 per mille of the maximum peak.
    localparam int  LIMIT_W           = 10;
    localparam logic [9:0] LIMIT_MAX  = 10'h3E8;
    localparam logic [9:0] LIMIT_SSM  = 10'h276;
    localparam logic [9:0] LIMIT_MIN  = 10'h0FB;

    // Demagnetization duty reference codes in per mille.
    localparam logic [9:0] DEMAG_NORMAL = 10'h1A9;
    localparam logic [9:0] DEMAG_SSM    = 10'h2DF;

    // Thresholds in millivolts, microamps or degrees C, kept as documentation of the comparator trips.
    localparam int  UV_ON_MV          = 21000;
    localparam int  UV_OFF_MV         = 7750;
    localparam int  SSM_ENTER_MV      = 1330;
    localparam int  SSM_EXIT_MV       = 1380;
    localparam int  OVP_MV            = 4600;
    localparam int  CS_MAX_MV         = 773;
    localparam int  CS_MIN_MV         = 194;
    localparam int  OCP_MV            = 1500;
    localparam int  LINE_RUN_UA       = 225;
    localparam int  LINE_STOP_UA      = 80;
    localparam int  OTP_DEG_C         = 165;

    typedef enum logic [2:0] {
        FBS_OFF    = 3'b000,
        FBS_PROBE  = 3'b001,
        FBS_RUN    = 3'b011,
        FBS_FAULT  = 3'b010,
        FBS_LINEWT = 3'b110
    } fbs_state_t;

    typedef enum logic [1:0] {
        FBS_PH_IDLE  = 2'b00,
        FBS_PH_ON    = 2'b01,
        FBS_PH_DEMAG = 2'b11,
        FBS_PH_WAIT  = 2'b10
    } fbs_phase_t;

endpackage : fbs_pkg

/* File: shared/fbs_sync_if.sv */
`timescale 1ns/1ps
interface fbs_sync_if #(
    parameter int WIDTH = 1
);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] clean;

    modport src (output raw, input clean);
    modport dst (input raw, output clean);
endinterface : fbs_sync_if

/* File: tb/fbs_power_model.sv */
`timescale 1ns/1ps
module fbs_power_model (
    input  wire logic ref_clk,    // Device clock.
    input  wire logic gate,       // Gate command from the device.
    input  wire logic no_ring,    // Ringing has decayed away.
    output logic      cs_trip,    // Sensed current at threshold.
    output logic      demag_done, // Secondary current has reached zero.
    output logic      smp_vld,    // Aux sample held.
    output logic      valley,     // Drain voltage valley.
    output logic      ring_to     // No valley found in time.
);
    int on_n  = 0;
    int off_n = 0;
    initial {cs_trip, demag_done, smp_vld, valley, ring_to} = 5'h00;
    always @(posedge ref_clk) begin
        on_n       <= gate ? on_n + 1 : 0;
        off_n      <= gate ? 0 : off_n + 1;
        // A turn-on spike trips the sense early, the real ramp trips it later.
        cs_trip    <= gate && (on_n inside {[1:4]} || on_n > 40);
        demag_done <= !gate && off_n > 20;
        smp_vld    <= !gate && off_n inside {[21:28]};
        valley     <= !gate && !no_ring && off_n > 24 && off_n[3:2] == 2'h0;
        ring_to    <= !gate && no_ring && off_n > 60;
    end
endmodule : fbs_power_model

/* File: tb/fbs_sequencer_sva.sv */
`timescale 1ns/1ps
module fbs_sequencer_sva
    import fbs_pkg::*;
(
    input wire logic               ref_clk,              // Device clock.
    input wire logic               reset,                // Synchronous reset.
    input wire logic               bias_below_off,       // Bias below turn-off.
    input wire logic               cs_ocp,               // Overcurrent level.
    input wire logic               over_temp,            // Over temperature.
    input wire logic               gate_drive_out,       // Gate command.
    input wire logic               startup_switch_on,    // Startup switch on.
    input wire logic               fault_current_on,     // Fault discharge.
    input wire logic [LIMIT_W-1:0] peak_limit,           // Peak limit code.
    input wire logic [LIMIT_W-1:0] demag_duty_reference, // Duty reference code.
    input wire logic               startup_mode          // Special startup mode.
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic [7:0] on_q;
    logic [7:0] on_d;
    always_comb on_d = !gate_drive_out ? 8'h00 : (on_q == 8'hFF ? on_q : on_q + 8'h01);
    always_ff @(posedge ref_clk) on_q <= reset ? 8'h00 : on_d;
    sequence ocp_held; cs_ocp[*8]; endsequence
    sequence hot_held; over_temp[*8]; endsequence
    sequence gate_end; $fell(gate_drive_out) && !fault_current_on && !startup_switch_on; endsequence
    chk_blank_hold: assert property (gate_end |-> on_q >= BLANK_CYCLES)
        else $error("gate ended inside blanking");
    chk_ocp_stop: assert property (ocp_held |-> !gate_drive_out)
        else $error("gate high under overcurrent");
    chk_hot_stop: assert property (hot_held |-> !gate_drive_out)
        else $error("gate high while hot");
    chk_fault_gate: assert property (fault_current_on |-> !gate_drive_out)
        else $error("gate high in fault");
    chk_bias_off: assert property (bias_below_off[*8] |-> startup_switch_on && !gate_drive_out)
        else $error("no lockout at low bias");
    chk_switch_gate: assert property (startup_switch_on |-> !gate_drive_out)
        else $error("gate high with startup switch on");
    chk_ssm_limit: assert property (startup_mode |-> peak_limit <= LIMIT_SSM && demag_duty_reference == DEMAG_SSM)
        else $error("startup mode limits wrong");
    chk_demag_norm: assert property (!startup_mode |-> demag_duty_reference == DEMAG_NORMAL)
        else $error("normal duty reference wrong");
    chk_limit_range: assert property (peak_limit >= LIMIT_MIN && peak_limit <= LIMIT_MAX)
        else $error("peak limit out of range");
    chk_fault_exit: assert property ($fell(fault_current_on) |-> startup_switch_on)
        else $error("fault left without restart");
endmodule : fbs_sequencer_sva
bind fbs_sequencer fbs_sequencer_sva u_fbs_sequencer_sva (.ref_clk, .reset, .bias_below_off, .cs_ocp, .over_temp,
    .gate_drive_out, .startup_switch_on, .fault_current_on, .peak_limit, .demag_duty_reference, .startup_mode);

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`define CMP(got, exp) begin compares++; if ((got) !== (exp)) begin error_cnt++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
    import fbs_pkg::*;
    logic ref_clk = 1'b0, reset = 1'b1, bias_above_on = 1'b0, bias_below_off = 1'b0, cs_ocp = 1'b0;
    logic aux_below_enter = 1'b0, aux_above_exit = 1'b0, aux_ovp = 1'b0, aux_lost = 1'b0, no_ring = 1'b0;
    logic line_run = 1'b1, line_stop = 1'b0, over_temp = 1'b0, in_regulation = 1'b0, hot_seen;
    logic [15:0] period_min = 16'h0064;
    logic [LIMIT_W-1:0] law_limit = LIMIT_MAX, law_m, peak_limit, demag_duty_reference;
    logic cs_trip, demag_done, aux_sample_valid, valley_det, ring_timeout;
    logic gate_drive_out, startup_switch_on, fault_current_on, startup_mode, cc_mode, ssm_m, reg_m;
    int seed = 32'h55A7, error_cnt = 0, compares = 0, cyc = 0, last_on, k, i;
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;
    fbs_sequencer #(.CNT_W(16)) u_fbs_sequencer (.ref_clk, .reset, .bias_above_on, .bias_below_off, .cs_trip,
        .cs_ocp, .aux_sample_valid, .aux_below_enter, .aux_above_exit, .aux_ovp, .aux_lost, .demag_done,
        .valley_det, .ring_timeout, .line_run, .line_stop, .over_temp, .in_regulation, .period_min, .law_limit,
        .gate_drive_out, .startup_switch_on, .fault_current_on, .peak_limit, .demag_duty_reference,
        .startup_mode, .cc_mode);
    fbs_power_model u_fbs_power_model (.ref_clk, .gate(gate_drive_out), .no_ring, .cs_trip, .demag_done,
        .smp_vld(aux_sample_valid), .valley(valley_det), .ring_to(ring_timeout));
    task automatic final_report;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report
    function automatic logic [LIMIT_W-1:0] exp_limit(input int n);
        if (n <= 3) return LIMIT_MIN;
        if (ssm_m) return LIMIT_SSM;
        return reg_m ? law_m : LIMIT_MAX;
    endfunction : exp_limit
    task automatic wait_for(input logic v, input int lim);
        int w;
        for (w = 0; gate_drive_out !== v && w < lim; w++) @(posedge ref_clk);
        if (w >= lim) begin
            error_cnt++;
            final_report();
        end
    endtask : wait_for
    // Waits for the next turn-on, then looks at the limit well inside the on-time, except on turn-ons 4 and 5.
    task automatic next_on(input int n);
        wait_for(1'b0, 4000);
        wait_for(1'b1, 4000);
        if (last_on >= 0) `CMP(cyc - last_on >= period_min, 1'b1)
        last_on = cyc;
        repeat (20) @(posedge ref_clk);
        if (n <= 3 || n >= 6) `CMP(peak_limit, exp_limit(n))
    endtask : next_on
    task automatic power_up(input logic blw);
        int n;
        period_min <= 16'(100 + ($random(seed) & 63));
        aux_below_enter <= blw;
        aux_above_exit <= !blw;
        law_limit <= LIMIT_MAX;
        bias_below_off <= 1'b0;
        bias_above_on <= 1'b1;
        {last_on, ssm_m, reg_m} = {-1, blw, 1'b0};
        for (n = 1; n <= 6; n++) begin
            next_on(n);
            `CMP(startup_switch_on, 1'b0)
        end
        `CMP(startup_mode, blw)
        `CMP(cc_mode, 1'b1)
    endtask : power_up
    initial begin
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (2) @(posedge ref_clk);
        `CMP({startup_switch_on, gate_drive_out, fault_current_on}, 3'h4)
        `CMP(peak_limit, LIMIT_MIN)
        for (k = 0; k < 5; k++) begin
            power_up(k == 0);
            if (k == 0) begin
                aux_below_enter <= 1'b0;
                aux_above_exit <= 1'b1;
                ssm_m = 1'b0;
                next_on(7);
                `CMP({startup_mode, demag_duty_reference}, {1'b0, DEMAG_NORMAL})
                in_regulation <= 1'b1;
                next_on(8);
                `CMP(cc_mode, 1'b0)
                reg_m = 1'b1;
                for (i = 0; i < 6; i++) begin
                    law_m = LIMIT_MIN + 10'($random(seed) & 511);
                    law_limit <= law_m;
                    no_ring <= (i > 3);
                    next_on(9);
                end
                {no_ring, in_regulation} <= 2'h0;
                bias_above_on <= 1'b0;
                bias_below_off <= 1'b1;
                repeat (10) @(posedge ref_clk);
                `CMP({startup_switch_on, gate_drive_out}, 2'h2)
            end else begin
                case (k)
                    1: cs_ocp <= 1'b1;
                    2: over_temp <= 1'b1;
                    3: aux_lost <= 1'b1;
                    default: aux_ovp <= 1'b1;
                endcase
                for (i = 0; fault_current_on !== 1'b1 && i < 400; i++) @(posedge ref_clk);
                if (i >= 400) begin
                    error_cnt++;
                    final_report();
                end
                `CMP(gate_drive_out, 1'b0)
                {cs_ocp, aux_lost, aux_ovp} <= 3'h0;
                repeat (40) @(posedge ref_clk);
                `CMP(fault_current_on, 1'b1)
                bias_above_on <= 1'b0;
                bias_below_off <= 1'b1;
                repeat (10) @(posedge ref_clk);
                `CMP({startup_switch_on, fault_current_on}, 2'h2)
                if (k == 2) begin
                    {bias_below_off, bias_above_on, hot_seen} <= 3'h2;
                    repeat (200) @(posedge ref_clk) hot_seen |= gate_drive_out;
                    `CMP(hot_seen, 1'b0)
                    over_temp <= 1'b0;
                end
            end
        end
        final_report();
    end
endmodule : testbench
